// >>> rtl/sysctl_regs_pkg.sv
// Function
// - Register 0 with secondary opcode 1 returns cache geometry word.
// - Cache class reads 0111 at 28:25; reserved 31:29, 23:22, 11:10 zero.
// - Bit 24 reads one: separate instruction and data caches.
// - Both words-per-line fields read 10, eight words per line.
// - Cache size fields use code 0000 for none, 0011..1011 for 4KB..1MB.
// - Associativity reads 010 when cache present, 000 when absent.
// - Base-size bits read 0 when cache present, 1 when absent.
// - Size and base-size values come from cache block inputs.
// - Register 0 with secondary opcode 2 returns RAM sizes.
// - RAM size word: sizes at 21:18 and 9:6, absent at 14 and 2.
// - RAM size fields use the cache size code, supplied by memories.
// - RAM absent bit is one when that memory is missing.
// - Control word read and written at register 1, secondary opcode 0.
// - Reserved control bits may read any value.
// - Control bits 19..16 hold RAM load modes and RAM enables.
// - 15..12: state-entry disable, round-robin, vector base, I-cache.
// - Bit 7 big-endian, bit 2 data cache enable, bit 0 protection enable.
// - Reset clears control bits; high-vector bit loads the init pin.
// - Access only in privileged mode, else undefined-instruction trap.
// - Register 0 with other secondary opcodes returns the identity word.
package sysctl_regs_pkg;
   localparam logic [3:0] REG_ID_GROUP = 4'h0;
   localparam logic [3:0] REG_CONTROL = 4'h1;
   localparam logic [2:0] OP2_CACHE_GEOM = 3'h1;
   localparam logic [2:0] OP2_RAM_SIZE = 3'h2;
   localparam logic [2:0] OP2_CONTROL = 3'h0;
   localparam logic [3:0] CACHE_CLASS = 4'h7;
   localparam int CLASS_LSB = 25;
   localparam int SPLIT_BIT = 24;
   localparam int DSIZE_LSB = 18;
   localparam int DASSOC_LSB = 15;
   localparam int DBASE_BIT = 14;
   localparam int DLINE_LSB = 12;
   localparam int ISIZE_LSB = 6;
   localparam int IASSOC_LSB = 3;
   localparam int IBASE_BIT = 2;
   localparam int ILINE_LSB = 0;
   localparam logic [1:0] LINE_8_WORDS = 2'h2;
   localparam logic [2:0] ASSOC_4WAY = 3'h2;
   localparam logic [2:0] ASSOC_ABSENT = 3'h0;
   localparam logic [3:0] SIZE_0KB = 4'h0;
   localparam logic [3:0] SIZE_4KB = 4'h3;
   localparam logic [3:0] SIZE_1MB = 4'hB;
   // writable control bits: 19:12, 7, 2, 0
   localparam logic [31:0] CTRL_MASK = 32'h000FF085;
   localparam logic [31:0] CTRL_RESET = 32'h00000000;
   localparam logic [31:0] CTRL_RSVD_ONES = 32'h00000078;
   localparam int HIVEC_BIT = 13;
   // arbitrary neutral identity value
   localparam logic [31:0] ID_WORD_DEFAULT = 32'h00000000;
endpackage

// >>> rtl/size_field_fmt.sv
`timescale 1ns/1ps
`default_nettype none
// formats one size/absent pair; size reads zero when the block is absent
module size_field_fmt
   import sysctl_regs_pkg::*;
(
   // from memory block
   input wire logic [3:0] sizeCode,
   input wire logic present,
   // formatted
   output logic [3:0] sizeOut,
   output logic absent,
   output logic [2:0] assoc
);
   always_comb begin
      sizeOut = present ? sizeCode : SIZE_0KB;
      absent = ~present;
      assoc = present ? ASSOC_4WAY : ASSOC_ABSENT;
   end
endmodule
`default_nettype wire

// >>> rtl/sysctl_cache_tcm_id_regs.sv
`timescale 1ns/1ps
`default_nettype none
module sysctl_cache_tcm_id_regs
   import sysctl_regs_pkg::*;
#(
   parameter logic [31:0] ID_WORD = ID_WORD_DEFAULT
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // coprocessor access from core
   input wire logic accValid,
   input wire logic accWrite,
   input wire logic accPrivileged,
   input wire logic [3:0] primarySel,
   input wire logic [2:0] secondaryOp,
   input wire logic [31:0] wrData,
   output logic [31:0] rdData,
   output logic rdValid,
   output logic undefTrap,
   // geometry from cache and memory blocks
   input wire logic [3:0] dataCacheSize,
   input wire logic dataCachePresent,
   input wire logic [3:0] instCacheSize,
   input wire logic instCachePresent,
   input wire logic [3:0] dramSize,
   input wire logic dramPresent,
   input wire logic [3:0] iramSize,
   input wire logic iramPresent,
   // reset strap
   input wire logic highVectorInitPin,
   // control outputs
   output logic iramLoadMode,
   output logic iramEnable,
   output logic dramLoadMode,
   output logic dramEnable,
   output logic stateEntryDisable,
   output logic roundRobin,
   output logic highVectors,
   output logic instCacheEnable,
   output logic bigEndian,
   output logic dataCacheEnable,
   output logic protEnable
);
   logic [3:0] dcSz, icSz, drSz, irSz;
   logic dcAbs, icAbs, drAbs, irAbs;
   logic [2:0] dcAs, icAs, drAs, irAs;
   logic [31:0] cacheWord, ramWord;
   logic [31:0] ctrl_ff, nxt_ctrl;
   logic [31:0] rdData_ff, nxt_rdData;
   logic rdValid_ff, nxt_rdValid;
   logic trap_ff, nxt_trap;
   logic strapPend_ff, nxt_strapPend;
   logic accOk;

   // size fields come from the blocks, forced to zero when a block is absent
   size_field_fmt u_data_cache (
      .sizeCode(dataCacheSize),
      .present(dataCachePresent),
      .sizeOut(dcSz),
      .absent(dcAbs),
      .assoc(dcAs)
   );
   size_field_fmt u_inst_cache (
      .sizeCode(instCacheSize),
      .present(instCachePresent),
      .sizeOut(icSz),
      .absent(icAbs),
      .assoc(icAs)
   );
   size_field_fmt u_dram (
      .sizeCode(dramSize),
      .present(dramPresent),
      .sizeOut(drSz),
      .absent(drAbs),
      .assoc()
   );
   size_field_fmt u_iram (
      .sizeCode(iramSize),
      .present(iramPresent),
      .sizeOut(irSz),
      .absent(irAbs),
      .assoc()
   );

   always_comb begin
      cacheWord = 32'h00000000;
      cacheWord[CLASS_LSB +: 4] = CACHE_CLASS;
      cacheWord[SPLIT_BIT] = 1'b1;
      cacheWord[DSIZE_LSB +: 4] = dcSz;
      cacheWord[DASSOC_LSB +: 3] = dcAs;
      cacheWord[DBASE_BIT] = dcAbs;
      cacheWord[DLINE_LSB +: 2] = LINE_8_WORDS;
      cacheWord[ISIZE_LSB +: 4] = icSz;
      cacheWord[IASSOC_LSB +: 3] = icAs;
      cacheWord[IBASE_BIT] = icAbs;
      cacheWord[ILINE_LSB +: 2] = LINE_8_WORDS;
      ramWord = 32'h00000000;
      ramWord[DSIZE_LSB +: 4] = drSz;
      ramWord[DBASE_BIT] = drAbs;
      ramWord[ISIZE_LSB +: 4] = irSz;
      ramWord[IBASE_BIT] = irAbs;
   end

   assign accOk = accValid & accPrivileged;

   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_rdData = rdData_ff;
      nxt_rdValid = 1'b0;
      nxt_trap = accValid & ~accPrivileged;
      nxt_strapPend = 1'b0;
      if (strapPend_ff) begin
         // first edge after release samples the vector strap
         nxt_ctrl[HIVEC_BIT] = highVectorInitPin;
      end
      if (accOk && accWrite && primarySel == REG_CONTROL &&
          secondaryOp == OP2_CONTROL) begin
         nxt_ctrl = wrData & CTRL_MASK;
      end
      if (accOk && !accWrite) begin
         nxt_rdValid = 1'b1;
         nxt_rdData = 32'h00000000;
         case (primarySel)
            REG_ID_GROUP: begin
               case (secondaryOp)
                  OP2_CACHE_GEOM: nxt_rdData = cacheWord;
                  OP2_RAM_SIZE: nxt_rdData = ramWord;
                  default: nxt_rdData = ID_WORD;
               endcase
            end
            REG_CONTROL: begin
               // reserved bits 6:3 always read as ones, whatever software writes
               nxt_rdData = ctrl_ff | CTRL_RSVD_ONES;
            end
            default: nxt_rdData = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_ff <= CTRL_RESET;
         rdData_ff <= 32'h00000000;
         rdValid_ff <= 1'b0;
         trap_ff <= 1'b0;
         strapPend_ff <= 1'b1;
      end else begin
         ctrl_ff <= nxt_ctrl;
         rdData_ff <= nxt_rdData;
         rdValid_ff <= nxt_rdValid;
         trap_ff <= nxt_trap;
         strapPend_ff <= nxt_strapPend;
      end
   end

   assign rdData = rdData_ff;
   assign rdValid = rdValid_ff;
   assign undefTrap = trap_ff;
   assign iramLoadMode = ctrl_ff[19];
   assign iramEnable = ctrl_ff[18];
   assign dramLoadMode = ctrl_ff[17];
   assign dramEnable = ctrl_ff[16];
   assign stateEntryDisable = ctrl_ff[15];
   assign roundRobin = ctrl_ff[14];
   assign highVectors = ctrl_ff[HIVEC_BIT];
   assign instCacheEnable = ctrl_ff[12];
   assign bigEndian = ctrl_ff[7];
   assign dataCacheEnable = ctrl_ff[2];
   assign protEnable = ctrl_ff[0];
endmodule
`default_nettype wire

// >>> tb/ctl_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ctl_regs_monitor #(
   parameter logic [31:0] ID_WORD = 32'h0
)
(
   input wire logic ref_clk, rstn, accValid, accWrite, accPrivileged,
   input wire logic [3:0] primarySel,
   input wire logic [2:0] secondaryOp,
   input wire logic [31:0] wrData, rdData,
   input wire logic rdValid, undefTrap, dataCachePresent, dramPresent,
   input wire logic iramPresent, iramEnable, protEnable, bigEndian,
   input wire logic roundRobin, dataCacheEnable
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   logic rd, wr, rd0;
   assign rd = accValid && !accWrite && accPrivileged;
   assign wr = accValid && accWrite && accPrivileged;
   assign rd0 = rd && primarySel == 4'h0;
   rd_answer_a: assert property (rd |=> rdValid && !undefTrap)
      else $error("read not answered");
   user_trap_a: assert property (accValid && !accPrivileged
      |=> undefTrap && !rdValid) else $error("no trap");
   cache_fixed_a: assert property (rd0 && secondaryOp == 3'h1
      |=> rdData[31:22] == 10'h03C && rdData[13:10] == 4'h8
      && rdData[1:0] == 2'h2) else $error("cache word fixed bits");
   cache_assoc_a: assert property (rd0 && secondaryOp == 3'h1
      |=> rdData[17:14] == ($past(dataCachePresent) ? 4'h4 : 4'h1))
      else $error("cache assoc or base");
   ram_word_a: assert property (rd0 && secondaryOp == 3'h2
      |=> rdData[14] == !$past(dramPresent) && rdData[17:15] == 3'h0
      && rdData[2] == !$past(iramPresent) && rdData[31:22] == 10'h0
      && rdData[13:10] == 4'h0 && rdData[5:3] == 3'h0
      && rdData[1:0] == 2'h0) else $error("ram size word");
   id_word_a: assert property (rd0 && !(secondaryOp inside {3'h1, 3'h2})
      |=> rdData == ID_WORD) else $error("identity word");
   ctrl_write_a: assert property (wr && primarySel == 4'h1
      && secondaryOp == 3'h0 |=> iramEnable == $past(wrData[18])
      && protEnable == $past(wrData[0]) && bigEndian == $past(wrData[7]))
      else $error("control write");
   ctrl_hold_a: assert property (!wr
      |=> $stable({roundRobin, dataCacheEnable, bigEndian}))
      else $error("control changed");
   cover property (rd0 && secondaryOp == 3'h1);
   cover property (accValid && !accPrivileged);
   cover property (wr && primarySel == 4'h1);
endmodule
bind sysctl_cache_tcm_id_regs ctl_regs_monitor #(.ID_WORD(ID_WORD)) mon (
   .ref_clk, .rstn, .accValid, .accWrite, .accPrivileged, .primarySel,
   .secondaryOp, .wrData, .rdData, .rdValid, .undefTrap, .dataCachePresent,
   .dramPresent, .iramPresent, .iramEnable, .protEnable, .bigEndian,
   .roundRobin, .dataCacheEnable);
`default_nettype wire

// >>> tb/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input wire logic ref_clk, rdValid, undefTrap,
   input wire logic [31:0] rdData,
   output logic accValid, accWrite, accPrivileged,
   output logic [3:0] primarySel,
   output logic [2:0] secondaryOp,
   output logic [31:0] wrData
);
   initial {accValid, accWrite, accPrivileged} = 3'h0;
   initial {primarySel, secondaryOp, wrData} = 39'h0;
   // one access, answer taken 1 ns after the taking edge
   task automatic acc(input logic w, p, input logic [3:0] s,
      input logic [2:0] o, input logic [31:0] d,
      output logic [31:0] q, output logic v, t);
      @(posedge ref_clk);
      #1;
      {accValid, accWrite, accPrivileged} = {1'h1, w, p};
      {primarySel, secondaryOp, wrData} = {s, o, d};
      @(posedge ref_clk);
      #1;
      accValid = 1'h0;
      wrData = ~d;
      {q, v, t} = {rdData, rdValid, undefTrap};
   endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sysctl_regs_pkg::*;
   localparam logic [31:0] ID_VAL = 32'h5A5A00C3; // arbitrary value
   logic ref_clk = 1'h0, rstn = 1'h0, hvPin = 1'h1, dP = 1'h0, iP = 1'h0;
   logic dRp = 1'h0, iRp = 1'h0, v, t, accValid, accWrite, accPrivileged;
   logic [3:0] primarySel, dSz = 4'h0, iSz = 4'h0, dRs = 4'h0, iRs = 4'h0;
   logic [2:0] secondaryOp;
   logic [31:0] wrData, rdData, ctl, q;
   logic rdValid, undefTrap, iLm, iEn, dLm, dEn, tEd, rr, hv, icE, be, dcE, pE;
   int miscompares = 0, checks = 0;
   always #25 ref_clk = ~ref_clk;
   assign ctl = {12'h0, iLm, iEn, dLm, dEn, tEd, rr, hv, icE, 4'h0, be,
      4'h0, dcE, 1'h0, pE};
   sysctl_cache_tcm_id_regs #(.ID_WORD(ID_VAL)) dut (.ref_clk, .rstn,
      .accValid, .accWrite, .accPrivileged, .primarySel, .secondaryOp,
      .wrData, .rdData, .rdValid, .undefTrap, .dataCacheSize(dSz),
      .dataCachePresent(dP), .instCacheSize(iSz), .instCachePresent(iP),
      .dramSize(dRs), .dramPresent(dRp), .iramSize(iRs), .iramPresent(iRp),
      .highVectorInitPin(hvPin), .iramLoadMode(iLm), .iramEnable(iEn),
      .dramLoadMode(dLm), .dramEnable(dEn), .stateEntryDisable(tEd),
      .roundRobin(rr), .highVectors(hv), .instCacheEnable(icE),
      .bigEndian(be), .dataCacheEnable(dcE), .protEnable(pE));
   core_model core (.ref_clk, .rdData, .rdValid, .undefTrap, .accValid,
      .accWrite, .accPrivileged, .primarySel, .secondaryOp, .wrData);
   task automatic chk(input string n, input logic [31:0] s, e);
      checks++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic rdchk(input string n, input logic [3:0] s,
      input logic [2:0] o, input logic [31:0] e);
      core.acc(1'h0, 1'h1, s, o, 32'h0, q, v, t);
      chk({n, " valid"}, {31'h0, v}, 32'h1);
      chk(n, q, e);
   endtask
   task automatic t_reset(input logic pin);
      rstn = 1'h0;
      hvPin = pin;
      repeat (6) @(posedge ref_clk);
      #1 rstn = 1'h1;
      @(posedge ref_clk);
      #1 chk("control after reset", ctl, {18'h0, pin, 13'h0});
      $display("reset test done");
   endtask
   task automatic t_geom;
      logic [9:0] cs [4] = '{10'h0F7, 10'h1CB, 10'h2E8, 10'h000};
      logic [31:0] e;
      foreach (cs[i]) begin
         {dSz, dP, iSz, iP} = cs[i];
         {iRs, iRp, dRs, dRp} = cs[i];
         e = 32'h0F002002;
         e[21:14] = dP ? {dSz, 4'h4} : 8'h1;
         e[9:2] = iP ? {iSz, 4'h4} : 8'h1;
         rdchk("cache word", 4'h0, 3'h1, e);
         e = 32'h0;
         e[21:14] = dRp ? {dRs, 4'h0} : 8'h1;
         e[9:2] = iRp ? {iRs, 4'h0} : 8'h1;
         rdchk("ram word", 4'h0, 3'h2, e);
      end
      $display("geometry test done");
   endtask
   task automatic t_ctrl;
      core.acc(1'h1, 1'h1, 4'h1, 3'h0, 32'h000FF0FD, q, v, t);
      chk("control outputs", ctl, CTRL_MASK);
      core.acc(1'h0, 1'h1, 4'h1, 3'h0, 32'h0, q, v, t);
      chk("control read", q & CTRL_MASK, CTRL_MASK);
      core.acc(1'h1, 1'h1, 4'h1, 3'h1, 32'h78, q, v, t);
      chk("wrong op write", ctl, CTRL_MASK);
      core.acc(1'h1, 1'h0, 4'h1, 3'h0, 32'h78, q, v, t);
      chk("user write trap", {30'h0, v, t}, 32'h1);
      chk("user write kept", ctl, CTRL_MASK);
      core.acc(1'h0, 1'h0, 4'h0, 3'h1, 32'h0, q, v, t);
      chk("user read trap", {30'h0, v, t}, 32'h1);
      core.acc(1'h1, 1'h1, 4'h1, 3'h0, 32'h78, q, v, t);
      chk("control cleared", ctl, 32'h0);
      $display("control test done");
   endtask
   task automatic t_id;
      logic [2:0] ops [3] = '{3'h0, 3'h3, 3'h7};
      foreach (ops[i]) rdchk("identity", 4'h0, ops[i], ID_VAL);
      rdchk("unmapped", 4'h5, 3'h0, 32'h0);
      $display("identity test done");
   endtask
   initial begin
      t_reset(1'h1);
      t_geom;
      t_ctrl;
      t_id;
      core.acc(1'h1, 1'h1, 4'h1, 3'h0, 32'h000FF0FD, q, v, t);
      t_reset(1'h0);
      end_sim;
   end
   initial begin
      #100000;
      miscompares++;
      end_sim;
   end
endmodule
`default_nettype wire
